// >>> pmp_cfg.svh
`ifndef PMP_CFG_SVH
`define PMP_CFG_SVH

// Rates are kept in kHz so that the fractional 2.5 MHz figure stays exact.
`define PMP_SYS_FREQ_KHZ 100000
`define PMP_RX_FREQ_10_KHZ 2500
`define PMP_RX_FREQ_100_KHZ 25000
`define PMP_RX_FREQ_1000_KHZ 125000
`define PMP_SER_FREQ_KHZ 625000

// Half a period of a generated clock, rounded down and never below one cycle.
`define PMP_HALF_CYCLES(f) ((`PMP_SYS_FREQ_KHZ / (2 * (f))) > 0 ? (`PMP_SYS_FREQ_KHZ / (2 * (f))) : 1)
`define PMP_RX_HALF_10 `PMP_HALF_CYCLES(`PMP_RX_FREQ_10_KHZ)
`define PMP_RX_HALF_100 `PMP_HALF_CYCLES(`PMP_RX_FREQ_100_KHZ)
`define PMP_RX_HALF_1000 `PMP_HALF_CYCLES(`PMP_RX_FREQ_1000_KHZ)
`define PMP_SER_HALF `PMP_HALF_CYCLES(`PMP_SER_FREQ_KHZ)

`define PMP_POWERUP_CYCLES 16
`define PMP_DIV_W 8
`define PMP_WORD_W 9
`define PMP_ERR_BIT 8
`define PMP_FIFO_DEPTH 4
`define PMP_SPEED_100_CODE 2'h1
`define PMP_SPEED_10_CODE 2'h0

`endif

// >>> pmp_pkg.sv
package pmp_pkg;
    typedef enum logic [1:0] {PMP_SPD_10, PMP_SPD_100, PMP_SPD_1000} pmp_speed_t;
    typedef enum logic {PMP_POWERUP, PMP_FUNCTIONAL} pmp_state_t;
    typedef enum logic {PMP_MODE_RGMII, PMP_MODE_SGMII} pmp_mode_t;
endpackage

// >>> pmp_fifo.sv
`timescale 1ns/10ps
// Dual-clock FIFO with gray-coded pointers; DEPTH must be a power of two, at least 4.
module pmp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input wire logic wr_clock,
    input wire logic wr_rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic rd_clock,
    input wire logic rd_rst_n,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin, next_wbin, wgray, next_wgray, rg_w1, rg_w2;
    logic [AW:0] rbin, next_rbin, rgray, next_rgray, wg_r1, wg_r2;
    logic push, pop;

    assign in_ready = (wgray != {~rg_w2[AW:AW-1], rg_w2[AW-2:0]});
    assign out_valid = (rgray != wg_r2);
    assign out_data = mem[rbin[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_wbin = push ? wbin + 1'b1 : wbin;
        next_wgray = next_wbin ^ (next_wbin >> 1);
        next_rbin = pop ? rbin + 1'b1 : rbin;
        next_rgray = next_rbin ^ (next_rbin >> 1);
    end

    always_ff @(posedge wr_clock) begin
        if (push) begin
            mem[wbin[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge wr_clock or negedge wr_rst_n) begin
        if (!wr_rst_n) begin
            wbin <= '0;
            wgray <= '0;
            rg_w1 <= '0;
            rg_w2 <= '0;
        end else begin
            wbin <= next_wbin;
            wgray <= next_wgray;
            rg_w1 <= rgray;
            rg_w2 <= rg_w1;
        end
    end

    always_ff @(posedge rd_clock or negedge rd_rst_n) begin
        if (!rd_rst_n) begin
            rbin <= '0;
            rgray <= '0;
            wg_r1 <= '0;
            wg_r2 <= '0;
        end else begin
            rbin <= next_rbin;
            rgray <= next_rgray;
            wg_r1 <= wgray;
            wg_r2 <= wg_r1;
        end
    end
endmodule

// >>> pmp_mac_pins.sv
// Operation
// - In parallel mode the transmit nibble is sampled on the MAC-supplied transmit clock.
// - The receive clock runs at 2.5, 25 or 50 MHz for 10, 100 or 1000 Mbps (half period of 20, 2 or 1 cycles of the 100 MHz clock).
// - In parallel mode the receive nibble is driven synchronous to the generated receive clock.
// - In serial mode a continuous 50 MHz differential clock (half period one 100 MHz cycle) is driven toward the MAC.
// - In serial mode receive data leaves serially on the differential output pair with the output clock.
// - The pin pull resistors are switched off once power-up ends and functional operation begins.
// - In parallel mode data valid and error are encoded on the receive control line on both edges.
`timescale 1ns/10ps
`include "pmp_cfg.svh"
module pmp_mac_pins import pmp_pkg::*; #(
    parameter int POWERUP_CYCLES = `PMP_POWERUP_CYCLES,
    parameter int FIFO_DEPTH = `PMP_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic mac_tx_clock,
    input wire logic [3:0] tx_data_pins,
    input wire logic tx_ctrl_pin,
    input wire logic mode_sgmii_pin,
    input wire logic [1:0] speed_sel,
    output logic rx_clock_pin,
    output logic [3:0] rx_data_pins,
    output logic rx_ctrl_pin,
    output logic pulls_enabled,
    output logic [7:0] tx_line_byte,
    output logic tx_line_error,
    output logic tx_line_valid,
    input wire logic tx_line_ready,
    output logic tx_overflow,
    input wire logic [7:0] rx_line_byte,
    input wire logic rx_line_error,
    input wire logic rx_line_valid,
    output logic rx_line_taken,
    output logic serial_rx_level,
    output logic serial_rx_fault
);
    localparam logic [`PMP_DIV_W-1:0] SER_HALF = `PMP_DIV_W'(`PMP_SER_HALF);

    function automatic logic [`PMP_DIV_W-1:0] rx_half(input logic [1:0] sel);
        case (sel)
            `PMP_SPEED_10_CODE: rx_half = `PMP_DIV_W'(`PMP_RX_HALF_10);
            `PMP_SPEED_100_CODE: rx_half = `PMP_DIV_W'(`PMP_RX_HALF_100);
            default: rx_half = `PMP_DIV_W'(`PMP_RX_HALF_1000);
        endcase
    endfunction

    // Link-side state, clocked by the MAC transmit clock.
    logic g_rst1, gtx_rst_n, act_g1, act_g2;
    logic [3:0] lo_nib, next_lo_nib, hi_nib_g, next_hi_nib_g;
    logic en_q, next_en_q, xer_q, next_xer_q, ovf_tog, next_ovf_tog;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [`PMP_WORD_W-1:0] fifo_in_data, fifo_out_data;

    // Core-side state.
    logic mode_s1, mode_s2, ovf_s1, ovf_s2, ovf_s3, rgmii_active, next_rgmii_active;
    logic sp1, sp2, sn1, sn2;
    pmp_state_t state, next_state;
    pmp_mode_t mode_q, next_mode_q;
    logic [15:0] pu_cnt, next_pu_cnt;
    logic next_pulls_enabled;
    logic [7:0] next_tx_line_byte;
    logic next_tx_line_error, next_tx_line_valid, next_tx_overflow;
    logic [`PMP_DIV_W-1:0] div_cnt, next_div_cnt, cur_half;
    logic [3:0] hi_nib, next_hi_nib, next_rx_data_pins;
    logic fall_ctrl, next_fall_ctrl, next_rx_clock_pin, next_rx_ctrl_pin, next_rx_line_taken;
    logic [7:0] shreg, next_shreg;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic ser_dat, ser_clk, next_ser_dat, next_ser_clk, functional;
    logic [3:0] rx_lo;
    logic ser_next_bit;

    assign functional = (state == PMP_FUNCTIONAL);
    assign cur_half = rx_half(speed_sel);
    assign rx_lo = rx_line_byte[3:0];
    assign ser_next_bit = shreg[0];

    always_ff @(posedge mac_tx_clock or negedge rst_n) begin
        if (!rst_n) begin
            g_rst1 <= 1'b0;
            gtx_rst_n <= 1'b0;
        end else begin
            g_rst1 <= 1'b1;
            gtx_rst_n <= g_rst1;
        end
    end

    // Rising edge carries the low nibble and enable, falling edge the high nibble and enable xor error.
    always_comb begin
        next_lo_nib = tx_data_pins;
        next_en_q = tx_ctrl_pin;
        next_hi_nib_g = tx_data_pins;
        next_xer_q = tx_ctrl_pin;
        fifo_in_valid = act_g2 && en_q;
        fifo_in_data = {en_q ^ xer_q, hi_nib_g, lo_nib};
        // The MAC cannot be stalled, so a byte that meets a full FIFO is lost and flagged.
        next_ovf_tog = ovf_tog ^ (fifo_in_valid && !fifo_in_ready);
    end

    always_ff @(posedge mac_tx_clock or negedge gtx_rst_n) begin
        if (!gtx_rst_n) begin
            lo_nib <= 4'h0;
            en_q <= 1'b0;
            ovf_tog <= 1'b0;
            act_g1 <= 1'b0;
            act_g2 <= 1'b0;
        end else begin
            lo_nib <= next_lo_nib;
            en_q <= next_en_q;
            ovf_tog <= next_ovf_tog;
            act_g1 <= rgmii_active;
            act_g2 <= act_g1;
        end
    end

    always_ff @(negedge mac_tx_clock or negedge gtx_rst_n) begin
        if (!gtx_rst_n) begin
            hi_nib_g <= 4'h0;
            xer_q <= 1'b0;
        end else begin
            hi_nib_g <= next_hi_nib_g;
            xer_q <= next_xer_q;
        end
    end

    pmp_fifo #(
        .WIDTH(`PMP_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .wr_clock(mac_tx_clock),
        .wr_rst_n(gtx_rst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .rd_clock(clock),
        .rd_rst_n(rst_n),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Mode is caught once at the end of power-up; switching pin functions live would glitch the MAC.
    always_comb begin
        next_state = state;
        next_pu_cnt = pu_cnt;
        next_mode_q = mode_q;
        next_pulls_enabled = pulls_enabled;
        case (state)
            PMP_POWERUP: begin
                if (pu_cnt == 16'h0000) begin
                    next_state = PMP_FUNCTIONAL;
                    next_mode_q = mode_s2 ? PMP_MODE_SGMII : PMP_MODE_RGMII;
                    next_pulls_enabled = 1'b0;
                end else begin
                    next_pu_cnt = pu_cnt - 16'h0001;
                end
            end
            PMP_FUNCTIONAL: begin
                next_pulls_enabled = 1'b0;
            end
            default: begin
                next_state = PMP_POWERUP;
            end
        endcase
        next_rgmii_active = (next_state == PMP_FUNCTIONAL) && (next_mode_q == PMP_MODE_RGMII);
        fifo_out_ready = !tx_line_valid || tx_line_ready;
        next_tx_line_valid = tx_line_valid;
        next_tx_line_byte = tx_line_byte;
        next_tx_line_error = tx_line_error;
        if (fifo_out_ready) begin
            next_tx_line_valid = fifo_out_valid;
            if (fifo_out_valid) begin
                next_tx_line_byte = fifo_out_data[7:0];
                next_tx_line_error = fifo_out_data[`PMP_ERR_BIT];
            end
        end
        next_tx_overflow = ovf_s2 ^ ovf_s3;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= PMP_POWERUP;
            pu_cnt <= 16'(POWERUP_CYCLES - 1);
            mode_q <= PMP_MODE_RGMII;
            pulls_enabled <= 1'b1;
            rgmii_active <= 1'b0;
            ovf_s1 <= 1'b0;
            ovf_s2 <= 1'b0;
            ovf_s3 <= 1'b0;
            tx_line_valid <= 1'b0;
            tx_line_byte <= 8'h00;
            tx_line_error <= 1'b0;
            tx_overflow <= 1'b0;
            sp1 <= 1'b0;
            sp2 <= 1'b0;
            sn1 <= 1'b0;
            sn2 <= 1'b0;
            serial_rx_level <= 1'b0;
            serial_rx_fault <= 1'b0;
        end else begin
            state <= next_state;
            pu_cnt <= next_pu_cnt;
            mode_q <= next_mode_q;
            pulls_enabled <= next_pulls_enabled;
            rgmii_active <= next_rgmii_active;
            ovf_s1 <= ovf_tog;
            ovf_s2 <= ovf_s1;
            ovf_s3 <= ovf_s2;
            tx_line_valid <= next_tx_line_valid;
            tx_line_byte <= next_tx_line_byte;
            tx_line_error <= next_tx_line_error;
            tx_overflow <= next_tx_overflow;
            // Serial input shares pins 1 and 0 of the transmit nibble.
            sp1 <= tx_data_pins[1];
            sp2 <= sp1;
            sn1 <= tx_data_pins[0];
            sn2 <= sn1;
            serial_rx_level <= functional && (mode_q == PMP_MODE_SGMII) && sp2;
            serial_rx_fault <= functional && (mode_q == PMP_MODE_SGMII) && (sp2 == sn2);
        end
    end

    // The strap synchroniser runs through reset so that it has settled before power-up ends, however short.
    always_ff @(posedge clock) begin
        mode_s1 <= mode_sgmii_pin;
        mode_s2 <= mode_s1;
    end

    // Receive engine; one divider serves the parallel clock or the serial clock as the mode asks.
    always_comb begin
        next_div_cnt = div_cnt;
        next_hi_nib = hi_nib;
        next_fall_ctrl = fall_ctrl;
        next_shreg = shreg;
        next_bit_cnt = bit_cnt;
        next_ser_dat = ser_dat;
        next_ser_clk = ser_clk;
        next_rx_clock_pin = rx_clock_pin;
        next_rx_data_pins = rx_data_pins;
        next_rx_ctrl_pin = rx_ctrl_pin;
        next_rx_line_taken = 1'b0;
        if (!functional) begin
            next_div_cnt = '0;
            next_rx_clock_pin = 1'b0;
            next_rx_data_pins = 4'h0;
            next_rx_ctrl_pin = 1'b0;
        end else if (mode_q == PMP_MODE_RGMII) begin
            if (div_cnt == '0) begin
                next_div_cnt = cur_half - 1'b1;
                next_rx_clock_pin = !rx_clock_pin;
                if (!rx_clock_pin) begin
                    if (rx_line_valid && !rx_line_taken) begin
                        next_rx_data_pins = rx_lo;
                        next_rx_ctrl_pin = 1'b1;
                        next_hi_nib = rx_line_byte[7:4];
                        next_fall_ctrl = !rx_line_error;
                        next_rx_line_taken = 1'b1;
                    end else begin
                        next_rx_data_pins = 4'h0;
                        next_rx_ctrl_pin = 1'b0;
                        next_hi_nib = 4'h0;
                        next_fall_ctrl = 1'b0;
                    end
                end else begin
                    next_rx_data_pins = hi_nib;
                    next_rx_ctrl_pin = fall_ctrl;
                end
            end else begin
                next_div_cnt = div_cnt - 1'b1;
            end
        end else begin
            if (div_cnt == '0) begin
                next_div_cnt = SER_HALF - 1'b1;
                next_ser_clk = !ser_clk;
                // Data moves on the falling edge so that it is stable at the rising one.
                if (ser_clk) begin
                    if (bit_cnt != 3'h0) begin
                        next_ser_dat = ser_next_bit;
                        next_shreg = {1'b0, shreg[7:1]};
                        next_bit_cnt = bit_cnt - 3'h1;
                    end else if (rx_line_valid && !rx_line_taken) begin
                        next_ser_dat = rx_line_byte[0];
                        next_shreg = {1'b0, rx_line_byte[7:1]};
                        next_bit_cnt = 3'h7;
                        next_rx_line_taken = 1'b1;
                    end else begin
                        next_ser_dat = 1'b0;
                    end
                end
            end else begin
                next_div_cnt = div_cnt - 1'b1;
            end
            next_rx_clock_pin = 1'b0;
            next_rx_ctrl_pin = 1'b0;
            next_rx_data_pins = {!next_ser_dat, next_ser_dat, !next_ser_clk, next_ser_clk};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= '0;
            hi_nib <= 4'h0;
            fall_ctrl <= 1'b0;
            shreg <= 8'h00;
            bit_cnt <= 3'h0;
            ser_dat <= 1'b0;
            ser_clk <= 1'b0;
            rx_clock_pin <= 1'b0;
            rx_data_pins <= 4'h0;
            rx_ctrl_pin <= 1'b0;
            rx_line_taken <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            hi_nib <= next_hi_nib;
            fall_ctrl <= next_fall_ctrl;
            shreg <= next_shreg;
            bit_cnt <= next_bit_cnt;
            ser_dat <= next_ser_dat;
            ser_clk <= next_ser_clk;
            rx_clock_pin <= next_rx_clock_pin;
            rx_data_pins <= next_rx_data_pins;
            rx_ctrl_pin <= next_rx_ctrl_pin;
            rx_line_taken <= next_rx_line_taken;
        end
    end

    a_tx_nibble_pair: assert property (@(posedge mac_tx_clock) disable iff (!gtx_rst_n)
        (act_g2 && tx_ctrl_pin) |=> (fifo_in_valid && fifo_in_data[3:0] == $past(tx_data_pins)))
        else $error("transmit nibble not captured on the rising edge");
    a_tx_idle_mode: assert property (@(posedge mac_tx_clock) disable iff (!gtx_rst_n)
        !act_g2 |-> !fifo_in_valid)
        else $error("transmit bytes accepted while parallel mode is inactive");
    a_rx_half_period: assert property (@(posedge clock) disable iff (!rst_n)
        (functional && mode_q == PMP_MODE_RGMII && div_cnt == '0) |=>
        (div_cnt == $past(cur_half) - 1'b1) && (rx_clock_pin != $past(rx_clock_pin)))
        else $error("receive clock half period wrong for the selected speed");
    a_rx_clock_hold: assert property (@(posedge clock) disable iff (!rst_n)
        (functional && mode_q == PMP_MODE_RGMII && div_cnt != '0) |=> $stable(rx_clock_pin))
        else $error("receive clock toggled before its half period ended");
    a_rx_low_nibble: assert property (@(posedge clock) disable iff (!rst_n)
        (functional && mode_q == PMP_MODE_RGMII && div_cnt == '0 && !rx_clock_pin && rx_line_valid && !rx_line_taken)
        |=> (rx_line_taken && rx_ctrl_pin && rx_data_pins == $past(rx_lo)))
        else $error("low receive nibble not driven at the rising edge");
    a_rx_ctrl_fall: assert property (@(posedge clock) disable iff (!rst_n)
        (functional && mode_q == PMP_MODE_RGMII && div_cnt == '0 && rx_clock_pin)
        |=> (rx_ctrl_pin == $past(fall_ctrl) && rx_data_pins == $past(hi_nib)))
        else $error("falling-edge control or high nibble wrong");
    a_ser_clock_diff: assert property (@(posedge clock) disable iff (!rst_n)
        (functional && mode_q == PMP_MODE_SGMII && $past(functional) && $past(div_cnt) == '0)
        |-> ($changed(rx_data_pins[0]) && rx_data_pins[1] == !rx_data_pins[0]))
        else $error("serial clock output not toggling as a differential pair");
    a_ser_data_shift: assert property (@(posedge clock) disable iff (!rst_n)
        (functional && mode_q == PMP_MODE_SGMII && div_cnt == '0 && ser_clk && bit_cnt != 3'h0)
        |=> (rx_data_pins[2] == $past(ser_next_bit) && rx_data_pins[3] == !rx_data_pins[2]))
        else $error("serial data bit out of order");
    a_pulls_off: assert property (@(posedge clock) disable iff (!rst_n)
        (state == PMP_POWERUP && pu_cnt == 16'h0000) |=> (functional && !pulls_enabled) ##1 !pulls_enabled)
        else $error("pull resistors still enabled in functional operation");
    a_pin_exclusive: assert property (@(posedge clock) disable iff (!rst_n)
        (functional && mode_q == PMP_MODE_SGMII) |-> (!rx_clock_pin && !rx_ctrl_pin))
        else $error("parallel receive pins active in serial mode");

    c_rx_byte_rgmii: cover property (@(posedge clock) disable iff (!rst_n)
        rx_line_taken && mode_q == PMP_MODE_RGMII);
    c_rx_byte_sgmii: cover property (@(posedge clock) disable iff (!rst_n)
        rx_line_taken && mode_q == PMP_MODE_SGMII);
    c_tx_byte_out: cover property (@(posedge clock) disable iff (!rst_n)
        tx_line_valid && tx_line_ready);
    c_tx_overflow: cover property (@(posedge clock) disable iff (!rst_n) tx_overflow);
endmodule

// >>> pmp_mac_model.sv
`timescale 1ns/10ps
module pmp_mac_model (
    output logic mac_tx_clock,
    output logic [3:0] tx_data_pins,
    output logic tx_ctrl_pin,
    input wire logic serial_mode,
    input wire logic ser_bit,
    input wire logic ser_fault
);
    logic [8:0] queue_q[$];
    logic [8:0] cur;
    logic busy;
    initial begin
        mac_tx_clock = 1'b0;
        tx_data_pins = 4'h5;
        tx_ctrl_pin = 1'b0;
        busy = 1'b0;
        cur = 9'h000;
        #3.7;
        forever #80 mac_tx_clock = ~mac_tx_clock;
    end
    task automatic push(input logic [7:0] b, input logic e);
        queue_q.push_back({e, b});
    endtask
    // Idle lines keep toggling so that a stale nibble never looks like a fresh byte.
    always @(negedge mac_tx_clock) begin
        if (serial_mode) begin
            tx_data_pins <= {~tx_data_pins[3:2], ser_bit, ser_fault ? ser_bit : ~ser_bit};
            // Control is held high in serial mode so that a leak through the parallel path would show.
            tx_ctrl_pin <= 1'b1;
            busy <= 1'b0;
        end else if (queue_q.size() > 0) begin
            cur = queue_q.pop_front();
            busy <= 1'b1;
            tx_data_pins <= cur[3:0];
            tx_ctrl_pin <= 1'b1;
        end else begin
            busy <= 1'b0;
            tx_data_pins <= ~tx_data_pins;
            tx_ctrl_pin <= 1'b0;
        end
    end
    always @(posedge mac_tx_clock) begin
        if (busy) begin
            tx_data_pins <= cur[7:4];
            tx_ctrl_pin <= ~cur[8];
        end else if (!serial_mode) begin
            tx_data_pins <= ~tx_data_pins;
        end
    end
endmodule

// >>> tb_pmp_mac_pins.sv
`timescale 1ns/10ps
module tb_pmp_mac_pins;
    import pmp_pkg::*;
    localparam int PU = 2;
    logic clock = 1'b0, rst_n = 1'b0, mac_tx_clock, tx_ctrl_pin, mode_sgmii_pin = 1'b0, rx_clock_pin, rx_ctrl_pin;
    logic [3:0] tx_data_pins, rx_data_pins;
    logic [1:0] speed_sel = 2'h2;
    logic pulls_enabled, tx_line_error, tx_line_valid, tx_line_ready = 1'b0, tx_overflow;
    logic [7:0] tx_line_byte, rx_line_byte = 8'h00;
    logic rx_line_error = 1'b0, rx_line_valid = 1'b0, rx_line_taken, serial_rx_level, serial_rx_fault;
    logic ser_bit = 1'b0, ser_fault = 1'b0;
    int n_fail = 0, checks = 0;
    always #5 clock = ~clock;
    pmp_mac_pins #(.POWERUP_CYCLES(PU), .FIFO_DEPTH(4)) uut (.clock(clock), .rst_n(rst_n),
        .mac_tx_clock(mac_tx_clock), .tx_data_pins(tx_data_pins), .tx_ctrl_pin(tx_ctrl_pin),
        .mode_sgmii_pin(mode_sgmii_pin), .speed_sel(speed_sel), .rx_clock_pin(rx_clock_pin),
        .rx_data_pins(rx_data_pins), .rx_ctrl_pin(rx_ctrl_pin), .pulls_enabled(pulls_enabled),
        .tx_line_byte(tx_line_byte), .tx_line_error(tx_line_error), .tx_line_valid(tx_line_valid),
        .tx_line_ready(tx_line_ready), .tx_overflow(tx_overflow), .rx_line_byte(rx_line_byte),
        .rx_line_error(rx_line_error), .rx_line_valid(rx_line_valid), .rx_line_taken(rx_line_taken),
        .serial_rx_level(serial_rx_level), .serial_rx_fault(serial_rx_fault));
    pmp_mac_model mac (.mac_tx_clock(mac_tx_clock), .tx_data_pins(tx_data_pins), .tx_ctrl_pin(tx_ctrl_pin),
        .serial_mode(mode_sgmii_pin), .ser_bit(ser_bit), .ser_fault(ser_fault));
    task automatic complete_run;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tmo(input string nm);
        n_fail++;
        $display("wrong value %s expected event seen timeout", nm);
        complete_run();
    endtask
    task automatic wait_taken;
        int i;
        for (i = 0; i < 200 && rx_line_taken !== 1'b1; i++) @(negedge clock);
        if (i == 200) tmo("rx_line_taken");
    endtask
    task automatic do_reset(input logic mode);
        @(negedge clock);
        mode_sgmii_pin = mode;
        rst_n = 1'b0;
        repeat (20) @(negedge clock);
        chk("pulls in reset", 8'h01, {7'h00, pulls_enabled});
        rst_n = 1'b1;
        @(negedge clock);
        chk("pulls in power-up", 8'h01, {7'h00, pulls_enabled});
        repeat (PU + 2) @(negedge clock);
        chk("pulls functional", 8'h00, {7'h00, pulls_enabled});
        repeat (80) @(negedge clock);
    endtask
    task automatic t_speed;
        int n, k;
        logic p;
        for (int s = 0; s < 4; s++) begin
            speed_sel = s[1:0];
            repeat (100) @(negedge clock);
            n = 0;
            k = 0;
            p = rx_clock_pin;
            for (int i = 0; i < 200 && k < 2; i++) begin
                @(negedge clock);
                if (p !== 1'b1 && rx_clock_pin === 1'b1) k++;
                if (k == 1) n++;
                p = rx_clock_pin;
            end
            if (k < 2) tmo("rx_clock_pin period");
            chk("rx clock period", (s == 0) ? 8'd40 : (s == 1) ? 8'd4 : 8'd2, n[7:0]);
        end
    endtask
    task automatic t_rx_bytes;
        speed_sel = 2'h2;
        rx_line_byte = 8'h3c;
        rx_line_valid = 1'b1;
        wait_taken();
        chk("rise half", 8'hcc, {rx_clock_pin, rx_ctrl_pin, 2'h0, rx_data_pins});
        rx_line_byte = 8'ha5;
        rx_line_error = 1'b1;
        @(negedge clock);
        chk("fall half", 8'h43, {rx_clock_pin, rx_ctrl_pin, 2'h0, rx_data_pins});
        @(negedge clock);
        chk("back to back rise", 8'he5, {rx_clock_pin, rx_ctrl_pin, rx_line_taken, 1'b0, rx_data_pins});
        rx_line_valid = 1'b0;
        @(negedge clock);
        chk("error fall half", 8'h0a, {rx_clock_pin, rx_ctrl_pin, 2'h0, rx_data_pins});
        @(negedge clock);
        chk("idle rise", 8'h80, {rx_clock_pin, rx_ctrl_pin, rx_line_taken, 1'b0, rx_data_pins});
        rx_line_error = 1'b0;
    endtask
    task automatic get_tx(input logic [7:0] b, input logic e);
        int i;
        for (i = 0; i < 300 && tx_line_valid !== 1'b1; i++) @(negedge clock);
        if (i == 300) tmo("tx_line_valid");
        chk("tx byte", b, tx_line_byte);
        chk("tx error", {7'h00, e}, {7'h00, tx_line_error});
        @(negedge clock);
    endtask
    task automatic t_tx;
        tx_line_ready = 1'b1;
        mac.push(8'h12, 1'b0);
        mac.push(8'hef, 1'b1);
        mac.push(8'h7a, 1'b0);
        get_tx(8'h12, 1'b0);
        get_tx(8'hef, 1'b1);
        get_tx(8'h7a, 1'b0);
    endtask
    task automatic t_overflow;
        int ov, extra;
        ov = 0;
        extra = 0;
        tx_line_ready = 1'b0;
        for (int i = 0; i < 7; i++) mac.push(8'h40 + i[7:0], 1'b0);
        repeat (160) begin
            @(negedge clock);
            if (tx_overflow === 1'b1) ov++;
        end
        chk("overflow seen", 8'h01, {7'h00, ov > 0});
        tx_line_ready = 1'b1;
        for (int i = 0; i < 4; i++) get_tx(8'h40 + i[7:0], 1'b0);
        repeat (60) begin
            if (tx_line_valid === 1'b1) extra++;
            @(negedge clock);
        end
        chk("bytes kept past full", 8'h01, {7'h00, extra <= 1});
    endtask
    task automatic t_serial;
        logic [7:0] got;
        int j;
        do_reset(1'b1);
        for (int i = 0; i < 8; i++) begin
            got[0] = rx_data_pins[0];
            @(negedge clock);
            chk("serial clock", {7'h00, ~got[0]}, {7'h00, rx_data_pins[0]});
            chk("serial clock pair", 8'h01, {7'h00, rx_data_pins[1] ^ rx_data_pins[0]});
            chk("parallel pins quiet", 8'h00, {6'h00, rx_clock_pin, rx_ctrl_pin});
        end
        rx_line_byte = 8'hb4;
        rx_line_valid = 1'b1;
        wait_taken();
        rx_line_valid = 1'b0;
        j = 0;
        for (int i = 0; i < 60 && j < 8; i++) begin
            @(negedge clock);
            if (rx_data_pins[0] === 1'b1) begin
                got[j] = rx_data_pins[2];
                chk("serial data pair", 8'h01, {7'h00, rx_data_pins[3] ^ rx_data_pins[2]});
                j++;
            end
        end
        chk("serial byte", 8'hb4, got);
        mac.push(8'h99, 1'b0);
        ser_bit = 1'b1;
        repeat (60) @(negedge clock);
        chk("serial in", 8'h01, {tx_line_valid, serial_rx_fault, 5'h00, serial_rx_level});
        ser_fault = 1'b1;
        repeat (60) @(negedge clock);
        chk("serial in fault", 8'h41, {tx_line_valid, serial_rx_fault, 5'h00, serial_rx_level});
    endtask
    initial begin
        do_reset(1'b0);
        t_speed();
        t_rx_bytes();
        t_tx();
        t_overflow();
        t_serial();
        complete_run();
    end
endmodule
